//--- dds_core.sv
// Synthesis core with APB register access and clock-mode selection.
// Assumes pclk is the core sample clock; analog loop and pads are outside.
// How it works
// - Phase accumulator adds tuning word, wraps 2^32
// - Phase maps through cosine into DAC sample
// - Zero tuning word holds present phase
// - Clear-phase bit forces accumulator output zero unless clock-stop is set
// - Powerup: active clear set, pending copy clear
// - Multiplier field is bits 7:3, register two
// - Multiplier 4..20 multiplies reference clock
// - Other multiplier values bypass, power down loop
// - Mode pin enables oscillator and its buffer
// - Clock-stop bit halts clock, oscillator stays
// - Register two bit 9 drives crystal output
`include "dds_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dds_core import dds_pkg::*; #(
  parameter int LUT_BITS = 8, // Phase bits into the cosine table
  parameter int LOCK_CYCLES = `LOCK_CYCLES // Lock wait, shortened in sims
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_mode_pin,
  output logic [13:0] dac_sample,
  output logic osc_enable,
  output logic xtal_out_enable,
  output logic pll_enable,
  output logic [4:0] pll_mult,
  output var clk_src_type clk_source,
  output logic pll_locked
);
  initial begin
    if (LUT_BITS < 4 || LUT_BITS > 12) $error("LUT_BITS out of range");
    if (LOCK_CYCLES < 1 || LOCK_CYCLES > 262143) $error("LOCK_CYCLES bad");
  end

  core_state_type s_q, s_d; // Whole state and its next value
  logic osc_mode_meta_q, osc_mode_q; // Mode pin synchroniser
  logic access; // Access phase of an APB transfer
  logic mult_in_range; // Active multiplier engages the loop
  logic [LUT_BITS-1:0] lut_idx; // Cosine table index
  logic [13:0] cos_val; // Table output
  // The whole state sits in one struct so that reset, next-state and
  // register stay in step; the pending and active copies share a type,
  // which makes the commit a single struct copy with no field left out.

  // Pin synchroniser, two stages before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_mode_meta_q <= 1'b0;
      osc_mode_q <= 1'b0;
    end else begin
      osc_mode_meta_q <= osc_mode_pin;
      osc_mode_q <= osc_mode_meta_q;
    end
  end

  // Cosine table, offset binary around mid-scale; real is elaboration only
  localparam int LUT_N = 1 << LUT_BITS;
  logic [13:0] cos_rom [LUT_N];
  for (genvar i = 0; i < LUT_N; i++) begin : g_rom
    localparam real ANG = 6.283185307179586 * i / LUT_N;
    assign cos_rom[i] = 14'(int'(8191.5 + 8191.0 * $cos(ANG)));
  end
  assign lut_idx = s_q.phase[31 -: LUT_BITS];
  assign cos_val = cos_rom[lut_idx];

  assign access = psel && penable;
  assign mult_in_range = (s_q.act.mult >= `MULT_MIN) &&
    (s_q.act.mult <= `MULT_MAX);

  // Power-up: active clear set while the pending copy stays clear, so
  // the converter rests at full-scale cosine until the first commit.
  // The reset branch below loads constants only; a computed reset value
  // would put logic in the asynchronous reset path.

  // Next-state logic for registers, accumulator and sample
  always_comb begin
    s_d = s_q;
    // Writes land in the pending copy only
    if (access && pwrite) begin
      unique case (paddr)
        `CTRL_ONE_OFS: begin
          s_d.pend.clr_phase = pwdata[`CLR_PHASE_BIT];
          s_d.pend.clk_stop = pwdata[`CLK_STOP_BIT];
        end
        `CTRL_TWO_OFS: begin
          s_d.pend.mult = pwdata[`MULT_HI:`MULT_LO];
          s_d.pend.xtal_out = pwdata[`XTAL_OUT_BIT];
        end
        `TUNING_OFS: s_d.pend.tuning = pwdata;
        default: ;
      endcase
    end
    // Commit strobe applies every pending value at once
    if (access && pwrite && paddr == `COMMIT_OFS) begin
      s_d.act = s_q.pend;
      if (s_q.pend.mult != s_q.act.mult)
        s_d.lock_cnt = 18'(LOCK_CYCLES); // Relock after change
    end else if (s_q.lock_cnt != '0) begin
      s_d.lock_cnt = s_q.lock_cnt - 18'd1;
    end
    // Accumulator: stop wins, then clear; zero word simply holds
    if (s_q.act.clk_stop)
      s_d.phase = s_q.phase; // No clock, nothing moves
    else if (s_q.act.clr_phase)
      s_d.phase = '0;
    else
      s_d.phase = s_q.phase + s_q.act.tuning;
    if (!s_q.act.clk_stop)
      s_d.sample = cos_val;
    // Read data, captured in the setup phase
    s_d.rdata = '0;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `CTRL_ONE_OFS: begin
          s_d.rdata[`CLR_PHASE_BIT] = s_q.pend.clr_phase;
          s_d.rdata[`CLK_STOP_BIT] = s_q.pend.clk_stop;
        end
        `CTRL_TWO_OFS: begin
          s_d.rdata[`MULT_HI:`MULT_LO] = s_q.pend.mult;
          s_d.rdata[`XTAL_OUT_BIT] = s_q.pend.xtal_out;
        end
        `TUNING_OFS: s_d.rdata = s_q.pend.tuning;
        `STATUS_OFS: s_d.rdata = {29'h0, s_q.lock_cnt == '0,
          s_q.act.clr_phase, osc_mode_q};
        default: ;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.act.clr_phase <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Bus answers: zero wait, unmapped addresses flag an error
  assign pready = 1'b1;
  assign pslverr = access && !(paddr inside {`CTRL_ONE_OFS, `CTRL_TWO_OFS,
    `TUNING_OFS, `COMMIT_OFS, `STATUS_OFS});
  assign prdata = s_q.rdata;
  assign dac_sample = s_q.sample;

  // Clock-source selection outputs
  assign osc_enable = osc_mode_q; // Kept on even when stopped
  assign xtal_out_enable = osc_mode_q && s_q.act.xtal_out;
  assign pll_enable = mult_in_range && !s_q.act.clk_stop;
  assign pll_mult = s_q.act.mult;
  assign pll_locked = (s_q.lock_cnt == '0);
  always_comb begin
    if (s_q.act.clk_stop) clk_source = SRC_STOP;
    else if (mult_in_range) clk_source = SRC_MULT;
    else clk_source = SRC_REF;
  end

  // Accumulator advances by the word each cycle
  accum_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.act.clr_phase && !s_q.act.clk_stop && !$past(s_q.act.clr_phase)
    && $past(s_q.act.tuning) == s_q.act.tuning
    |=> s_q.phase == $past(s_q.phase) + $past(s_q.act.tuning))
    else $error("Accumulator step wrong");
  // Zero word holds phase
  zero_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.act.tuning == '0 && !s_q.act.clr_phase |=> $stable(s_q.phase))
    else $error("Zero word moved phase");
  // Clear forces zero
  clear_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.act.clr_phase && !s_q.act.clk_stop |=> s_q.phase == '0)
    else $error("Clear did not zero phase");
  // Sample follows table
  sample_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s_q.act.clk_stop |=> dac_sample == $past(cos_val))
    else $error("Sample not cosine of phase");
  // Bypass outside range
  mult_bypass_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.act.mult < 5'h04 || s_q.act.mult > 5'h14) |->
    !pll_enable && clk_source != SRC_MULT)
    else $error("Loop engaged out of range");
  // Multiply inside range
  mult_engage_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.act.mult inside {[5'h04:5'h14]} && !s_q.act.clk_stop |->
    pll_enable && clk_source == SRC_MULT)
    else $error("Loop not engaged in range");
  // Stop wins; source is checked in the same cycle, since a commit may
  // lift the stop at the very next edge
  clk_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.act.clk_stop |-> clk_source == SRC_STOP ##1 $stable(s_q.phase))
    else $error("Clock stop ignored");
  // Crystal buffer output
  xtal_buf_a: assert property (@(posedge pclk) disable iff (!presetn)
    xtal_out_enable == (osc_mode_q && s_q.act.xtal_out) &&
    osc_enable == osc_mode_q)
    else $error("Oscillator enables wrong");
  // Pending held until commit
  commit_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(access && pwrite && paddr == `COMMIT_OFS) |=> $stable(s_q.act))
    else $error("Active settings changed without commit");
  // Multiplier field position
  mult_field_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == `CTRL_TWO_OFS |=>
    s_q.pend.mult == $past(pwdata[7:3]))
    else $error("Multiplier field misplaced");
  // A committed multiplier change drops the lock indication
  lock_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == `COMMIT_OFS &&
    s_q.pend.mult != s_q.act.mult |=> !pll_locked)
    else $error("Lock not restarted on change");
  // Lock counter runs down one per cycle
  lock_count_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.lock_cnt != '0 && !(access && pwrite && paddr == `COMMIT_OFS) |=>
    s_q.lock_cnt == $past(s_q.lock_cnt) - 18'd1)
    else $error("Lock counter step wrong");
  // Unmapped writes leave pending settings alone
  bad_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && !(paddr inside {`CTRL_ONE_OFS, `CTRL_TWO_OFS,
    `TUNING_OFS, `COMMIT_OFS, `STATUS_OFS}) |=> $stable(s_q.pend))
    else $error("Unmapped write changed settings");
  // Read data stands only through the access phase
  read_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    access |=> prdata == '0)
    else $error("Read data not cleared");
  // Tuning word lands in the pending copy
  pend_tuning_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == `TUNING_OFS |=>
    s_q.pend.tuning == $past(pwdata))
    else $error("Tuning word not pended");
  // Clear bit lands in the pending copy
  clr_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == `CTRL_ONE_OFS |=>
    s_q.pend.clr_phase == $past(pwdata[10]))
    else $error("Clear bit misplaced");
  // Stopped clock freezes the sample as well
  stop_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.act.clk_stop |=> $stable(dac_sample))
    else $error("Sample moved while stopped");
  // Stopped clock powers the loop down
  stop_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.act.clk_stop |-> !pll_enable)
    else $error("Loop on while stopped");
  // Oscillator enable follows the second synchroniser stage
  osc_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
    osc_enable == $past(osc_mode_meta_q))
    else $error("Oscillator enable not synchronised");
endmodule
`default_nettype wire

//--- dds_cfg.svh
// Constants for the synthesis core: register offsets, fields, resets.
// Assumes inclusion by the core module and the testbench only.
`ifndef DDS_CFG_SVH
`define DDS_CFG_SVH
// Register byte offsets on the APB slave
`define CTRL_ONE_OFS 12'h000
`define CTRL_TWO_OFS 12'h004
`define TUNING_OFS 12'h010
`define COMMIT_OFS 12'h020
`define STATUS_OFS 12'h024
// Field positions of the first control register
`define CLR_PHASE_BIT 10
`define CLK_STOP_BIT 4
// Field positions of the second control register
`define MULT_HI 7
`define MULT_LO 3
`define XTAL_OUT_BIT 9
// Multiplier range that engages the loop
`define MULT_MIN 5'h04
`define MULT_MAX 5'h14
// Reset values
`define CTRL_ONE_RST 32'h0000_0000
`define CTRL_TWO_RST 32'h0000_0000
`define TUNING_RST 32'h0000_0000
// Loop lock settling time in us, and cycles at 125 MHz
`define LOCK_TIME_US 1000
`define CLK_MHZ 125
`define LOCK_CYCLES (`LOCK_TIME_US * `CLK_MHZ)
`endif

//--- dds_pkg.sv
// Types shared by the synthesis core.
// Assumes the constants header is available on the include path.
package dds_pkg;
  // Settings that steer the core, pending or active
  typedef struct packed {
    logic [31:0] tuning;
    logic clr_phase;
    logic clk_stop;
    logic [4:0] mult;
    logic xtal_out;
  } settings_type;
  // Clock source choice
  typedef enum logic [1:0] {SRC_REF, SRC_MULT, SRC_STOP} clk_src_type;
  // Whole state of the core
  typedef struct packed {
    settings_type pend;
    settings_type act;
    logic [31:0] phase;
    logic [13:0] sample;
    logic [31:0] rdata;
    logic [17:0] lock_cnt;
  } core_state_type;
endpackage

//--- far_side.sv
// Far-side model: the converter taking samples, and the mode strap.
// Assumes pclk is the core clock that the reference source makes.
`timescale 1ns/1ps
`default_nettype none
module far_side (
  input wire logic pclk,
  input wire logic [13:0] dac_sample,
  input wire logic mode_req,
  output logic osc_mode_pin,
  output logic [13:0] dac_held
);
  // Strap follows the bench; the reference rate is low enough that
  // every multiplier tried stays inside the mode's clock range
  assign osc_mode_pin = mode_req;
  // Converter latches one sample per core clock
  always_ff @(posedge pclk) begin
    dac_held <= dac_sample;
  end
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the synthesis core over APB.
// Assumes the far-side model and the core are compiled first.
`include "dds_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dds_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, mode_req, osc_mode_pin;
  logic pready, pslverr, osc_enable, xtal_out_enable, pll_enable;
  logic pll_locked;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic [13:0] dac_sample, dac_held, sa, sb;
  logic [4:0] pll_mult;
  logic [4:0] mlist [6]; // Multiplier values to visit
  clk_src_type clk_source;
  logic [32:0] expq [$]; // Expected {slave error, read data}
  int fails, tests_run, w;
  // Short lock count keeps the run brief
  dds_core #(.LOCK_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_mode_pin(osc_mode_pin), .dac_sample(dac_sample),
    .osc_enable(osc_enable), .xtal_out_enable(xtal_out_enable),
    .pll_enable(pll_enable), .pll_mult(pll_mult),
    .clk_source(clk_source), .pll_locked(pll_locked));
  far_side partner (.pclk(pclk), .dac_sample(dac_sample),
    .mode_req(mode_req), .osc_mode_pin(osc_mode_pin), .dac_held(dac_held));
  // Free-running core clock, 8 ns
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  // Commit strobe, then let the new settings reach the converter
  task automatic commit;
    apb(1'b1, `COMMIT_OFS, 32'h0);
    repeat (4) @(posedge pclk);
    #1;
  endtask
  task automatic pair;
    @(posedge pclk);
    #1 sa = dac_held;
    @(posedge pclk);
    #1 sb = dac_held;
  endtask
  // Read results are compared as they complete
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      check({pslverr, prdata}, expq.pop_front());
    end
  end
  task automatic test_done;
    $display("Counts: %0d compared, %0d mismatched", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata, mode_req} = 45'h1;
    rnd = $urandom(32'h3E2C4A41);
    mlist = '{5'h03, 5'h04, 5'h14, 5'h15, 5'($urandom), 5'h0A};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(`STATUS_OFS, 33'h7);
    rd(`CTRL_ONE_OFS, 33'h0);
    rd(12'h0FC, {1'b1, 32'h0});
    apb(1'b1, `TUNING_OFS, 32'h8000_0000);
    pair;
    check(33'({sa[13:8], sb[13:8]}), 33'hFFF);
    commit;
    pair;
    check(33'(sa[13:8] ^ sb[13:8]), 33'h3F);
    apb(1'b1, `TUNING_OFS, 32'h0);
    commit;
    pair;
    check(33'(sa), 33'(sb));
    apb(1'b1, `CTRL_ONE_OFS, 32'h400);
    apb(1'b1, `TUNING_OFS, 32'h8000_0000);
    commit;
    pair;
    check(33'({sa[13:8], sb[13:8]}), 33'hFFF);
    rd(`STATUS_OFS, 33'h7);
    $display("Phase tests done");
    foreach (mlist[i]) begin
      apb(1'b1, `CTRL_TWO_OFS, 32'(mlist[i]) << 3);
      commit;
      check(33'(pll_mult), 33'(mlist[i]));
      w = (mlist[i] >= 5'h04 && mlist[i] <= 5'h14) ? 1 : 0;
      check(33'(pll_enable), 33'(w));
      check(33'(clk_source), w ? 33'(SRC_MULT) : 33'(SRC_REF));
      for (w = 0; w < 40 && pll_locked !== 1'b1; w++) @(posedge pclk);
      check(33'(pll_locked), 33'h1);
    end
    $display("Multiplier tests done");
    apb(1'b1, `TUNING_OFS, rnd | 32'h1);
    apb(1'b1, `CTRL_ONE_OFS, 32'h10);
    commit;
    pair;
    check(33'(clk_source), 33'(SRC_STOP));
    check(33'({pll_enable, osc_enable}), 33'h1);
    check(33'(sa), 33'(sb));
    rd(`TUNING_OFS, {1'b0, rnd | 32'h1});
    $display("Clock stop test done");
    apb(1'b1, `CTRL_TWO_OFS, 32'h200);
    commit;
    for (int v = 0; v < 2; v++) begin
      @(posedge pclk);
      mode_req <= v[0];
      repeat (4) @(posedge pclk);
      #1;
      check(33'({osc_enable, xtal_out_enable}), {31'h0, {2{v[0]}}});
    end
    apb(1'b1, `CTRL_TWO_OFS, 32'h0);
    commit;
    check(33'({osc_enable, xtal_out_enable}), 33'h2);
    $display("Oscillator tests done");
    test_done;
  end
  // Watchdog, far beyond the expected run
  initial begin
    #100000;
    fails++;
    test_done;
  end
endmodule
`default_nettype wire
